// file: hw/hbf_protect.sv
// Contract
// - set open-load flag after under-load delay
// - one global open-load timer, shared remainder
// - timer runs while any under-load persists
// - shutdown enabled: disable output, latch error
// - shutdown disabled: flag only, output driven
// - open-load flag held until status reset
// - over-current past delay sets flag, disables
// - status reset clears over-current, re-enables
// - thermal warning follows temperature, outputs untouched
// - thermal shutdown latches channel off, sets flags
// - shutdown cleared only when cool and reset
// - motor under-voltage past delay: fail, all off
// - motor supply recovers: resume, clear fail
// - logic under-voltage: bus stops, all cleared
// - logic supply recovers: event and reset released
// - over-voltage sets fail; off if lockout selected
// - over-voltage not latched, recovers by itself
// - non-latched lockouts restore previous output state
// - status reset acts at end of transfer
// - enable low sleeps, clears registers, outputs off
`default_nettype none
module hbf_protect #(
  parameter int OL_CYCLES = hbf_pkg::OPEN_LOAD_DELAY_CYC,
  parameter int OC_CYCLES = hbf_pkg::OVERCURRENT_DELAY_CYC,
  parameter int UV_CYCLES = hbf_pkg::UV_DELAY_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and analog comparators, asynchronous
  input wire logic enable_pin,
  input wire logic logic_supply_uv,
  input wire logic motor_supply_uv,
  input wire logic motor_supply_ov,
  input wire logic [hbf_pkg::NCH-1:0] ls_under_load,
  input wire logic [hbf_pkg::NCH-1:0] over_current,
  input wire logic [hbf_pkg::NCH-1:0] temp_warn,
  input wire logic [hbf_pkg::NCH-1:0] temp_shutdown,
  // bridge output switch drives; both low is high impedance
  output logic [hbf_pkg::NCH-1:0] bridge_output_hs,
  output logic [hbf_pkg::NCH-1:0] bridge_output_ls
);
  import hbf_pkg::*;

  localparam int SW = 4 + 4 * NCH; // synchronised input width

  logic [SW-1:0] sync1_q; // first stage, read only by stage two
  logic [SW-1:0] sync2_q; // stable copies
  logic en_s, vcc_uv_s, msup_uv_s, msup_ov_s;
  logic [NCH-1:0] ul_s, oc_s, warn_s, tsd_s;
  logic sleep; // sleep or logic undervoltage
  logic [NCH-1:0] hb_en_q; // channel active
  logic [NCH-1:0] hb_cfg_q; // 1 high side on, 0 low side on
  logic open_load_shutdown_enable_q;
  logic overvoltage_lockout_select_q;
  logic status_reset_command; // one-cycle pulse at write completion
  logic [NCH-1:0] open_load_flag_q, ol_off_q, overcurrent_flag_q;
  logic [NCH-1:0] thermal_warning_flag_q, thermal_shutdown_flag_q;
  logic uv_fail_q, supply_fail_flag_q;
  logic [TMR_W-1:0] ol_cnt_q; // global open-load timer
  logic [TMR_W-1:0] oc_cnt_q [NCH]; // per-channel over-current timers
  logic [TMR_W-1:0] uv_cnt_q; // motor undervoltage timer
  logic [NCH-1:0] ul, ol_qual, oc_qual, ch_off, hs_d, ls_d;
  logic off_all;
  logic [NCH-1:0] hs_q, ls_q;
  // bus state
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write;

  // saturating timer step
  function automatic logic [TMR_W-1:0] tmr_next(input logic run, input logic [TMR_W-1:0] c,
                                                 input int lim);
    if (!run) begin
      return '0;
    end
    if (c >= TMR_W'(lim)) begin
      return TMR_W'(lim);
    end
    return c + TMR_W'(1);
  endfunction : tmr_next

  // two-flop synchroniser for every pin and comparator input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= {enable_pin, logic_supply_uv, motor_supply_uv, motor_supply_ov,
                  temp_shutdown, temp_warn, over_current, ls_under_load};
      sync2_q <= sync1_q;
    end
  end

  // unpack synchronised inputs
  assign {en_s, vcc_uv_s, msup_uv_s, msup_ov_s, tsd_s, warn_s, oc_s, ul_s} = sync2_q;
  assign sleep = !en_s || vcc_uv_s;

  // write completion; status reset acts here only
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign status_reset_command = do_write && aw_addr_q == CTRL_OFS && w_strb_q[3] &&
                                w_data_q[CTRL_STRST_BIT];

  // write address/data capture, bus stalls in logic undervoltage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (clk_en) begin
      awready_q <= !aw_have_q && !bvalid_q && !(s_axi_awvalid && awready_q) &&
                   !vcc_uv_s;
      wready_q <= !w_have_q && !bvalid_q && !(s_axi_wvalid && wready_q) && !vcc_uv_s;
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        // status and output state are read-only, ignored with okay
        bresp_q <= (aw_addr_q == CTRL_OFS || aw_addr_q == STATUS_OFS ||
                    aw_addr_q == OUTS_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // control register, cleared in sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {overvoltage_lockout_select_q, open_load_shutdown_enable_q, hb_cfg_q, hb_en_q} <=
        CTRL_RESET;
    end else if (clk_en) begin
      if (sleep) begin
        {overvoltage_lockout_select_q, open_load_shutdown_enable_q, hb_cfg_q, hb_en_q} <=
          CTRL_RESET;
      end else if (do_write && aw_addr_q == CTRL_OFS) begin
        if (w_strb_q[0]) begin
          hb_en_q <= w_data_q[CTRL_EN_LSB +: NCH];
          hb_cfg_q[1:0] <= w_data_q[CTRL_CFG_LSB +: 2];
        end
        if (w_strb_q[1]) begin
          hb_cfg_q[NCH-1:2] <= w_data_q[CTRL_CFG_LSB+2 +: NCH-2];
          open_load_shutdown_enable_q <= w_data_q[CTRL_OLSHUT_BIT];
          overvoltage_lockout_select_q <= w_data_q[CTRL_OVLOCK_BIT];
        end
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      arready_q <= !rvalid_q && !(s_axi_arvalid && arready_q) && !vcc_uv_s;
      if (s_axi_arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= RESP_OKAY;
        rdata_q <= '0;
        unique case (s_axi_araddr)
          CTRL_OFS: begin
            rdata_q[CTRL_EN_LSB +: NCH] <= hb_en_q;
            rdata_q[CTRL_CFG_LSB +: NCH] <= hb_cfg_q;
            rdata_q[CTRL_OLSHUT_BIT] <= open_load_shutdown_enable_q;
            rdata_q[CTRL_OVLOCK_BIT] <= overvoltage_lockout_select_q;
          end
          STATUS_OFS: begin
            rdata_q[ST_OL_LSB +: NCH] <= open_load_flag_q;
            rdata_q[ST_OVC_LSB +: NCH] <= overcurrent_flag_q;
            rdata_q[ST_WARN_LSB +: NCH] <= thermal_warning_flag_q;
            rdata_q[ST_TSHUT_LSB +: NCH] <= thermal_shutdown_flag_q;
            rdata_q[ST_SFAIL_BIT] <= supply_fail_flag_q;
          end
          OUTS_OFS: begin
            rdata_q[OUTS_HS_LSB +: NCH] <= hs_q;
            rdata_q[OUTS_LS_LSB +: NCH] <= ls_q;
          end
          default: begin
            rresp_q <= RESP_SLVERR; // unmapped
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // open-load sensing only on driven low sides
  assign ul = ul_s & ls_q;
  // all channels under load qualify at the shared expiry
  assign ol_qual = ul & {NCH{ol_cnt_q == TMR_W'(OL_CYCLES)}};

  // global open-load timer, saturates so late channels use the remainder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ol_cnt_q <= '0;
    end else if (clk_en) begin
      ol_cnt_q <= tmr_next(|ul, ol_cnt_q, OL_CYCLES);
    end
  end

  // open-load flag and latched shutdown; set beats status reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_load_flag_q <= '0;
      ol_off_q <= '0;
    end else if (clk_en) begin
      if (sleep) begin
        open_load_flag_q <= '0;
        ol_off_q <= '0;
      end else begin
        open_load_flag_q <= (open_load_flag_q & ~{NCH{status_reset_command}}) | ol_qual;
        ol_off_q <= (ol_off_q & ~{NCH{status_reset_command}}) |
                    (ol_qual & {NCH{open_load_shutdown_enable_q}});
      end
    end
  end

  // over-current timers per channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCH; i++) begin
        oc_cnt_q[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NCH; i++) begin
        oc_cnt_q[i] <= tmr_next(oc_s[i], oc_cnt_q[i], OC_CYCLES);
      end
    end
  end

  // qualified over-current
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      oc_qual[i] = oc_s[i] && oc_cnt_q[i] == TMR_W'(OC_CYCLES);
    end
  end

  // over-current, thermal flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_flag_q <= '0;
      thermal_warning_flag_q <= '0;
      thermal_shutdown_flag_q <= '0;
    end else if (clk_en) begin
      if (sleep) begin
        overcurrent_flag_q <= '0;
        thermal_warning_flag_q <= '0;
        thermal_shutdown_flag_q <= '0;
      end else begin
        overcurrent_flag_q <= (overcurrent_flag_q & ~{NCH{status_reset_command}}) |
                              oc_qual;
        thermal_warning_flag_q <= warn_s | tsd_s;
        // clear only when cooled and reset written
        thermal_shutdown_flag_q <= (thermal_shutdown_flag_q &
                                    ~({NCH{status_reset_command}} & ~tsd_s)) | tsd_s;
      end
    end
  end

  // motor supply undervoltage and supply-fail flag, never latched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_cnt_q <= '0;
      uv_fail_q <= 1'b0;
      supply_fail_flag_q <= 1'b0;
    end else if (clk_en) begin
      uv_cnt_q <= tmr_next(msup_uv_s, uv_cnt_q, UV_CYCLES);
      uv_fail_q <= msup_uv_s && (uv_fail_q || uv_cnt_q == TMR_W'(UV_CYCLES));
      supply_fail_flag_q <= !sleep && ((msup_uv_s && (uv_fail_q || uv_cnt_q == TMR_W'(UV_CYCLES)))
                            || msup_ov_s);
    end
  end

  // lockouts gate without touching the control register
  assign off_all = sleep || uv_fail_q ||
                   (msup_ov_s && overvoltage_lockout_select_q);
  assign ch_off = ~hb_en_q | ol_off_q | overcurrent_flag_q | thermal_shutdown_flag_q |
                  {NCH{off_all}};
  assign hs_d = ~ch_off & hb_cfg_q;
  assign ls_d = ~ch_off & ~hb_cfg_q;

  // output switch drives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_q <= '0;
      ls_q <= '0;
    end else if (clk_en) begin
      hs_q <= hs_d;
      ls_q <= ls_d;
    end
  end

  assign bridge_output_hs = hs_q;
  assign bridge_output_ls = ls_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_oc_output_off: assert property ((clk_en && |overcurrent_flag_q) |=>
    ((hs_q | ls_q) & $past(overcurrent_flag_q)) == '0) else $error("over-current output on");
  a_ol_off_flagged: assert property ((ol_off_q & ~open_load_flag_q) == '0)
    else $error("open-load shutdown without flag");
  a_ol_timer_clear: assert property ((clk_en && ul == '0) |=> ol_cnt_q == '0)
    else $error("open-load timer not cleared");
  a_ol_qualify: assert property ((clk_en && !sleep && ol_qual != '0) |=>
    (open_load_flag_q & $past(ol_qual)) == $past(ol_qual)) else $error("open load missed");
  a_ol_no_shut: assert property ((clk_en && !sleep && !open_load_shutdown_enable_q) |=>
    ol_off_q == $past(ol_off_q & ~{NCH{status_reset_command}})) else $error("open-load shut");
  a_warn_follow: assert property ((clk_en && !sleep) |=>
    thermal_warning_flag_q == $past(warn_s | tsd_s)) else $error("warning flag wrong");
  a_tsd_hold: assert property (
    (clk_en && !sleep && |(thermal_shutdown_flag_q & tsd_s)) |=> |thermal_shutdown_flag_q)
    else $error("shutdown cleared while hot");
  a_uv_resume: assert property ((clk_en && !msup_uv_s) |=> !uv_fail_q)
    else $error("undervoltage not released");
  a_sleep_off: assert property ((clk_en && sleep) |=> ##1
    (!clk_en || (hs_q | ls_q) == '0)) else $error("output on in sleep");
  a_ov_flag: assert property ((clk_en && !sleep && msup_ov_s) |=> supply_fail_flag_q)
    else $error("over-voltage flag missing");

  c_ol_qualify: cover property (clk_en && |ol_qual);
  c_oc_trip: cover property (clk_en && |oc_qual);
  c_status_reset: cover property (clk_en && status_reset_command && |overcurrent_flag_q);
  c_uv_trip: cover property (clk_en && uv_fail_q);

endmodule : hbf_protect
`default_nettype wire

// file: hw/hbf_pkg.sv
`default_nettype none
package hbf_pkg;
  // channel count and clock rate
  localparam int NCH = 6;
  localparam int CLK_PERIOD_NS = 100;
  // qualification times in ns (least times, rounded up to whole cycles)
  localparam int OPEN_LOAD_DELAY_NS = 100000;
  localparam int OVERCURRENT_DELAY_NS = 10000;
  localparam int UV_DELAY_NS = 20000;
  localparam int OPEN_LOAD_DELAY_CYC = (OPEN_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVERCURRENT_DELAY_CYC =
    (OVERCURRENT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UV_DELAY_CYC = (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // timer width
  localparam int TMR_W = 16;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] OUTS_OFS = 8'h08;
  // control register fields
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_CFG_LSB = 6;
  localparam int CTRL_OLSHUT_BIT = 12;
  localparam int CTRL_OVLOCK_BIT = 13;
  localparam int CTRL_STRST_BIT = 31;
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  // status register fields
  localparam int ST_OL_LSB = 0;
  localparam int ST_OVC_LSB = 6;
  localparam int ST_WARN_LSB = 12;
  localparam int ST_TSHUT_LSB = 18;
  localparam int ST_SFAIL_BIT = 24;
  // output state register fields
  localparam int OUTS_HS_LSB = 0;
  localparam int OUTS_LS_LSB = 6;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hbf_pkg
`default_nettype wire

// file: bench/hbf_host.sv
`default_nettype none
// bus master standing in for the host controller
module hbf_host (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // write: address and data offered together, each dropped when taken
  task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : write
  // read: address held until taken, then wait for data
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : read
  // control write with the status reset bit set on top of the control value
  task automatic status_reset(input logic [31:0] c);
    logic [1:0] r;
    write(8'h00, c | 32'h8000_0000, 4'hf, r);
  endtask : status_reset
endmodule : hbf_host
`default_nettype wire

// file: bench/half_bridge_fault_protection_tb.sv
`default_nettype none
module half_bridge_fault_protection_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hbf_pkg::*;
  // shortened qualification counts
  localparam int OL = 10;
  localparam int OC = 6;
  localparam int UV = 5;
  // ch0..2 high side on, ch3..5 low side on, all channels enabled
  localparam logic [31:0] BASE = 32'h0000_01ff;
  logic aclk, aresetn, clk_en, enable_pin, lsuv, muv, mov;
  logic [NCH-1:0] ul, oc, twarn, thermal_shutdown_flag, hs, ls;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wr_r;
  int miscompares, check_count;
  hbf_protect #(.OL_CYCLES(OL), .OC_CYCLES(OC), .UV_CYCLES(UV)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .enable_pin(enable_pin), .logic_supply_uv(lsuv), .motor_supply_uv(muv),
    .motor_supply_ov(mov), .ls_under_load(ul), .over_current(oc), .temp_warn(twarn),
    .temp_shutdown(thermal_shutdown_flag), .bridge_output_hs(hs), .bridge_output_ls(ls));
  hbf_host u_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // register read with response check; 0x0c is unmapped
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0] r;
    u_host.read(a, d, r);
    chk(n, e, d);
    chk("rresp", 32'((a > OUTS_OFS) ? RESP_SLVERR : RESP_OKAY), 32'(r));
  endtask : rd
  // output register and pins against expected drives
  task automatic outs(input logic [NCH-1:0] h, input logic [NCH-1:0] l);
    rd(OUTS_OFS, {20'h0, l, h}, "outs reg");
    @(negedge aclk);
    chk("pins", {20'h0, l, h}, {20'h0, ls, hs});
    @(posedge aclk);
  endtask : outs
  task automatic wr(input logic [31:0] v);
    u_host.write(CTRL_OFS, v, 4'hf, wr_r);
    chk("bresp", 32'(RESP_OKAY), 32'(wr_r));
  endtask : wr
  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // watchdog against a hung handshake
  initial begin
    cyc(20000);
    miscompares++;
    $display("[FAIL] watchdog expected end seen hang");
    print_verdict();
  end
  // main sequence
  initial begin
    {aresetn, lsuv, muv, mov, ul, oc, twarn, thermal_shutdown_flag} = '0;
    enable_pin = 1'b1;
    clk_en = 1'b1;
    miscompares = 0;
    check_count = 0;
    cyc(12);
    aresetn <= 1'b1;
    cyc(6);
    rd(CTRL_OFS, 32'h0, "ctrl reset");
    rd(STATUS_OFS, 32'h0, "status reset");
    rd(8'h0c, 32'h0, "unmapped");
    u_host.write(8'h0c, 32'h0, 4'hf, wr_r);
    chk("bresp unmapped", 32'(RESP_SLVERR), 32'(wr_r));
    u_host.write(STATUS_OFS, 32'hffff_ffff, 4'hf, wr_r);
    chk("bresp ro", 32'(RESP_OKAY), 32'(wr_r));
    rd(STATUS_OFS, 32'h0, "status ro");
    wr(BASE);
    rd(CTRL_OFS, BASE, "ctrl rw");
    // byte 1 only: upper configs and option bits cleared, enables kept
    u_host.write(CTRL_OFS, 32'h0, 4'h2, wr_r);
    rd(CTRL_OFS, 32'h0000_00ff, "ctrl strobe");
    wr(BASE);
    outs(6'h07, 6'h38);
    done("registers");
    // short dip must not qualify
    ul <= 6'h08;
    cyc(OL - 4);
    ul <= 6'h00;
    cyc(OL + 8);
    rd(STATUS_OFS, 32'h0, "ol transient");
    // ch4 starts late, finishes on the shared timer
    ul <= 6'h08;
    cyc(7);
    ul <= 6'h18;
    cyc(8);
    rd(STATUS_OFS, 32'h18, "ol global");
    outs(6'h07, 6'h38);
    ul <= 6'h00;
    cyc(6);
    rd(STATUS_OFS, 32'h18, "ol held");
    u_host.status_reset(BASE);
    rd(STATUS_OFS, 32'h0, "ol cleared");
    done("open load flag");
    wr(BASE | 32'h1000);
    ul <= 6'h20;
    cyc(OL + 8);
    ul <= 6'h00;
    cyc(6);
    rd(STATUS_OFS, 32'h20, "olsd flag");
    outs(6'h07, 6'h18);
    u_host.status_reset(BASE);
    outs(6'h07, 6'h38);
    done("open load shutdown");
    oc <= 6'h01;
    cyc(OC + 8);
    oc <= 6'h00;
    cyc(6);
    rd(STATUS_OFS, 32'h40, "oc flag");
    // reset bit without its byte strobe is no command
    u_host.write(CTRL_OFS, BASE | 32'h8000_0000, 4'h7, wr_r);
    rd(STATUS_OFS, 32'h40, "oc no byte3");
    outs(6'h06, 6'h38);
    u_host.status_reset(BASE);
    rd(STATUS_OFS, 32'h0, "oc cleared");
    outs(6'h07, 6'h38);
    done("overcurrent");
    twarn <= 6'h02;
    cyc(6);
    rd(STATUS_OFS, 32'h2000, "warn set");
    outs(6'h07, 6'h38);
    twarn <= 6'h00;
    cyc(6);
    rd(STATUS_OFS, 32'h0, "warn auto");
    thermal_shutdown_flag <= 6'h02;
    cyc(6);
    rd(STATUS_OFS, 32'h82000, "tsd set");
    outs(6'h05, 6'h38);
    u_host.status_reset(BASE);
    rd(STATUS_OFS, 32'h82000, "tsd hot");
    thermal_shutdown_flag <= 6'h00;
    cyc(6);
    outs(6'h05, 6'h38);
    u_host.status_reset(BASE);
    rd(STATUS_OFS, 32'h0, "tsd cleared");
    outs(6'h07, 6'h38);
    done("thermal");
    muv <= 1'b1;
    cyc(UV + 8);
    rd(STATUS_OFS, 32'h0100_0000, "uv psf");
    outs(6'h00, 6'h00);
    muv <= 1'b0;
    cyc(6);
    rd(STATUS_OFS, 32'h0, "uv gone");
    outs(6'h07, 6'h38);
    mov <= 1'b1;
    cyc(6);
    rd(STATUS_OFS, 32'h0100_0000, "ov psf");
    outs(6'h07, 6'h38);
    wr(BASE | 32'h2000);
    cyc(4);
    outs(6'h00, 6'h00);
    mov <= 1'b0;
    cyc(6);
    rd(STATUS_OFS, 32'h0, "ov gone");
    outs(6'h07, 6'h38);
    done("supply");
    // clock enable low freezes everything, even the pin synchroniser
    clk_en <= 1'b0;
    enable_pin <= 1'b0;
    cyc(6);
    @(negedge aclk);
    chk("frozen pins", {20'h0, 6'h38, 6'h07}, {20'h0, ls, hs});
    @(posedge aclk);
    clk_en <= 1'b1;
    cyc(6);
    outs(6'h00, 6'h00);
    rd(CTRL_OFS, 32'h0, "sleep ctrl");
    enable_pin <= 1'b1;
    cyc(6);
    wr(BASE);
    outs(6'h07, 6'h38);
    lsuv <= 1'b1;
    cyc(6);
    @(negedge aclk);
    chk("lsuv pins", 32'h0, {20'h0, ls, hs});
    @(posedge aclk);
    lsuv <= 1'b0;
    cyc(6);
    rd(CTRL_OFS, 32'h0, "lsuv ctrl");
    rd(STATUS_OFS, 32'h0, "lsuv status");
    done("sleep");
    print_verdict();
  end
endmodule : half_bridge_fault_protection_tb
`default_nettype wire
